// ---- core/reset_flags_consts.vh ----
// Behaviour
// - Trap conflict reset sets bit 15; cleared only by rst, power-on or software.
// - Illegal opcode, address mode or uninitialised pointer reset sets bit 14.
// - Bit 13 turns brown-out detection on or off; zero after power-on.
// - Bits 12, 11 and 9 read zero and ignore writes.
// - Sleep with deep sleep enabled sets bit 10; software or power-on clears.
// - Bit 8 keeps program memory bias powered in sleep when set.
// - Master clear pin reset sets bit 7; power-on clears it.
// - Reset instruction sets bit 6; power-on clears it.
// - Bit 5 enables watchdog; fuse at one forces watchdog on regardless.
// - Watchdog time-out sets bit 4; power-save instruction or power-on clears.
// - Sleep instruction sets bit 3, idle instruction sets bit 2.
// - Bit 1 set by every brown-out and power-on reset; reset value one.
// - Bit 0 set by power-on reset; reset value one.
// - Software may set or clear flags; setting never causes a reset.
// - With switching on, power-on/brown-out take initial select, except fast RC on a two-speed power-on; others keep current.
// - With switching off, clock source comes from configuration bits, except fast RC on a two-speed power-on.
// - Release delay: power-on plus timer, brown-out timer only, others none.
// - Power-up timer delay is 64 ms when enabled, else zero.
// - Crystal and secondary sources wait 1024 oscillator periods on 10-bit counter.
// - Clock delays run alongside release delay; execution waits for both.
// - Two-speed start-up begins on fast RC oscillator after power-on.
// - Clock-fail monitor starts only after its own delay past reset release.
// - Any active reset source asserts the single system reset.
`ifndef RESET_FLAGS_CONSTS_VH
`define RESET_FLAGS_CONSTS_VH
`define RCC_ADDR 12'h000
`define RCC_RESET 16'h0003
`define RCC_WMASK 16'he5ff
`define BIT_TRAP 15
`define BIT_ILLOP 14
`define BIT_SW_BROWNOUT_ENABLE 13
`define BIT_DEEP_SLEEP_FLAG 10
`define BIT_PROGMEM_SLEEP_POWER 8
`define BIT_PIN 7
`define BIT_SOFT 6
`define BIT_SWDT 5
`define BIT_WATCHDOG_TIMEOUT_FLAG 4
`define BIT_SLEEP 3
`define BIT_IDLE 2
`define BIT_BOR 1
`define BIT_POR 0
`define OSC_FRC 3'h0
`define CLK_HZ 50000000
`define POWERUP_TIMER_MS 64
`define POWERUP_TIMER_CYCLES ((`POWERUP_TIMER_MS * (`CLK_HZ / 1000)))
`define POR_DELAY_CYCLES 1000
`define OST_PERIODS 1024
`define LOCK_CYCLES 2000
`define CLOCK_FAIL_MONITOR_CYCLES 100
`endif

// ---- core/reset_flags_and_release_timing.v ----
`timescale 1ns/100ps
`include "reset_flags_consts.vh"
module reset_flags_and_release_timing #(
   parameter [31:0] powerup_timer_cycles = `POWERUP_TIMER_CYCLES,
   parameter [31:0] por_cycles = `POR_DELAY_CYCLES,
   parameter [31:0] lock_cycles = `LOCK_CYCLES
) (
   input wire clk,
   input wire rst,
   input wire ce,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   output wire [31:0] prdata,
   output wire pready,
   output wire pslverr,
   input wire por_event,
   input wire bor_event,
   input wire pin_reset_n,
   input wire reset_instr,
   input wire wdt_timeout,
   input wire trap_conflict,
   input wire illegal_op,
   input wire sleep_instr,
   input wire idle_instr,
   input wire deep_sleep_en,
   input wire watchdog_fuse_enable,
   input wire clk_switch_en,
   input wire two_speed_en,
   input wire powerup_timer_en,
   input wire clock_fail_monitor_en,
   input wire [2:0] initial_osc_select,
   input wire needs_ost,
   input wire needs_pll,
   input wire osc_tick,
   output reg system_reset,
   output reg cpu_run,
   output reg [2:0] current_osc_select,
   output reg clock_fail_monitor_on,
   output wire brownout_enable,
   output wire watchdog_enable,
   output wire progmem_sleep_power
);

// =====================================================
// Pin and oscillator synchronisers
reg pin_s1;
reg pin_s2;
reg osc_s1;
reg osc_s2;
reg osc_d;
wire pin_rst;
wire osc_edge;

// The pin idles high, so the chain resets high and rst leaves no false pin reset
always @(posedge clk or posedge rst) begin
   if (rst) begin
      pin_s1 <= 1'b1;
      pin_s2 <= 1'b1;
   end else if (ce) begin
      pin_s1 <= pin_reset_n;
      pin_s2 <= pin_s1;
   end
end
assign pin_rst = ~pin_s2;

// The oscillator must run well below clk, or its edges are lost in sampling
always @(posedge clk or posedge rst) begin
   if (rst) begin
      osc_s1 <= 1'b0;
      osc_s2 <= 1'b0;
      osc_d <= 1'b0;
   end else if (ce) begin
      osc_s1 <= osc_tick;
      osc_s2 <= osc_s1;
      osc_d <= osc_s2;
   end
end
assign osc_edge = osc_s2 & ~osc_d;

// =====================================================
// Reset sources
wire any_src = por_event | bor_event | pin_rst | reset_instr | wdt_timeout | trap_conflict | illegal_op;

// =====================================================
// Register decode
function reg_hit;
   input [11:0] a;
   begin
      reg_hit = (a == `RCC_ADDR);
   end
endfunction

reg [15:0] rcc;
reg [15:0] next_rcc;
wire wr_acc = psel & penable & pwrite & reg_hit(paddr);
wire [15:0] wdat = pwdata[15:0] & `RCC_WMASK;

// =====================================================
// Flag update
always @* begin
   next_rcc = rcc;
   // Software write first so hardware sets in the same cycle win
   if (wr_acc) begin
      next_rcc = wdat;
   end
   // A time-out in the same cycle outranks the power-save clear
   if (wdt_timeout == 1'b0 && (sleep_instr | idle_instr)) begin
      next_rcc[`BIT_WATCHDOG_TIMEOUT_FLAG] = 1'b0;
   end
   if (trap_conflict) begin
      next_rcc[`BIT_TRAP] = 1'b1;
   end
   if (illegal_op) begin
      next_rcc[`BIT_ILLOP] = 1'b1;
   end
   if (sleep_instr & deep_sleep_en) begin
      next_rcc[`BIT_DEEP_SLEEP_FLAG] = 1'b1;
   end
   if (pin_rst) begin
      next_rcc[`BIT_PIN] = 1'b1;
   end
   if (reset_instr) begin
      next_rcc[`BIT_SOFT] = 1'b1;
   end
   if (wdt_timeout) begin
      next_rcc[`BIT_WATCHDOG_TIMEOUT_FLAG] = 1'b1;
   end
   if (sleep_instr) begin
      next_rcc[`BIT_SLEEP] = 1'b1;
   end
   if (idle_instr) begin
      next_rcc[`BIT_IDLE] = 1'b1;
   end
   if (bor_event) begin
      next_rcc[`BIT_BOR] = 1'b1;
   end
   if (por_event) begin
      // Power-on wipes everything except the two power flags
      next_rcc = `RCC_RESET;
   end
end

// Cause flags sit outside the reset they record, so system_reset never clears them; rst, power-on and software writes do
always @(posedge clk or posedge rst) begin
   if (rst) begin
      rcc <= `RCC_RESET;
   end else if (ce) begin
      rcc <= next_rcc;
   end
end

assign brownout_enable = rcc[`BIT_SW_BROWNOUT_ENABLE];
assign watchdog_enable = rcc[`BIT_SWDT] | watchdog_fuse_enable;
assign progmem_sleep_power = rcc[`BIT_PROGMEM_SLEEP_POWER];

// =====================================================
// Read path
reg [31:0] rdata;
reg [31:0] rd_word;
always @* begin
   rd_word = 32'h00000000;
   if (reg_hit(paddr)) begin
      rd_word = {16'h0000, rcc};
   end
end

// Captured at the setup edge so that the access phase answers with no wait state
always @(posedge clk or posedge rst) begin
   if (rst) begin
      rdata <= 32'h00000000;
   end else if (ce && psel && !penable && !pwrite) begin
      rdata <= rd_word;
   end
end
assign prdata = rdata;
assign pready = 1'b1;
assign pslverr = psel & penable & ~reg_hit(paddr);

// =====================================================
// Release timing
localparam ST_IDLE = 3'b001;
localparam ST_HOLD = 3'b010;
localparam ST_WAIT = 3'b100;
reg [2:0] state;
reg [2:0] next_state;
reg [31:0] rst_cnt;
reg [31:0] clk_cnt;
reg [9:0] ost_cnt;
reg ost_done;
reg clk_ok;
reg [31:0] clock_fail_monitor_cnt;
wire clock_fail_monitor_run = !system_reset && clock_fail_monitor_en && !clock_fail_monitor_on;

function [31:0] delay_for;
   input p;
   input b;
   input t;
   reg [31:0] timer;
   begin
      // The power-up timer adds nothing at all when it is disabled
      timer = t ? powerup_timer_cycles : 32'h00000000;
      if (p) begin
         delay_for = por_cycles + timer;
      end else if (b) begin
         delay_for = timer;
      end else begin
         delay_for = 32'h00000000;
      end
   end
endfunction

// =====================================================
// Release state machine
always @* begin
   next_state = state;
   case (state)
      ST_HOLD: begin
         if (rst_cnt == 32'h00000000) begin
            next_state = ST_WAIT;
         end
      end
      ST_WAIT: begin
         if (clk_ok) begin
            next_state = ST_IDLE;
         end
      end
      ST_IDLE: begin
         next_state = ST_IDLE;
      end
      default: begin
         next_state = ST_HOLD;
      end
   endcase
   if (any_src) begin
      next_state = ST_HOLD;
   end
end

always @(posedge clk or posedge rst) begin
   if (rst) begin
      state <= ST_HOLD;
   end else if (ce) begin
      state <= next_state;
   end
end

// A source held over several cycles keeps reloading the count
always @(posedge clk or posedge rst) begin
   if (rst) begin
      rst_cnt <= 32'h00000000;
   end else if (ce) begin
      if (any_src) begin
         rst_cnt <= delay_for(por_event, bor_event, powerup_timer_en);
      end else if (state == ST_HOLD && rst_cnt != 32'h00000000) begin
         rst_cnt <= rst_cnt - 32'h00000001;
      end
   end
end

always @(posedge clk or posedge rst) begin
   if (rst) begin
      system_reset <= 1'b1;
   end else if (ce) begin
      if (any_src) begin
         system_reset <= 1'b1;
      end else if (state == ST_HOLD && rst_cnt == 32'h00000000) begin
         system_reset <= 1'b0;
      end
   end
end

// Code runs only once both the release delay and the clock delay are over
always @(posedge clk or posedge rst) begin
   if (rst) begin
      cpu_run <= 1'b0;
   end else if (ce) begin
      if (any_src) begin
         cpu_run <= 1'b0;
      end else if (state == ST_WAIT && clk_ok) begin
         cpu_run <= 1'b1;
      end
   end
end

// =====================================================
// Oscillator start-up counter
always @(posedge clk or posedge rst) begin
   if (rst) begin
      ost_cnt <= 10'h000;
      ost_done <= 1'b0;
   end else if (ce) begin
      if (any_src) begin
         ost_cnt <= 10'h000;
         // Sources without a crystal need no start-up count
         ost_done <= ~needs_ost;
      end else if (!ost_done && osc_edge) begin
         ost_cnt <= ost_cnt + 10'h001;
         if (ost_cnt == 10'h3ff) begin
            ost_done <= 1'b1;
         end
      end
   end
end

// =====================================================
// Lock wait
always @(posedge clk or posedge rst) begin
   if (rst) begin
      clk_cnt <= 32'h00000000;
      clk_ok <= 1'b0;
   end else if (ce) begin
      if (any_src) begin
         clk_cnt <= needs_pll ? lock_cycles : 32'h00000000;
         clk_ok <= 1'b0;
      end else begin
         // Runs alongside the release count rather than after it
         if (clk_cnt != 32'h00000000) begin
            clk_cnt <= clk_cnt - 32'h00000001;
         end
         clk_ok <= ost_done && (clk_cnt == 32'h00000000);
      end
   end
end

// =====================================================
// Clock source at reset
always @(posedge clk or posedge rst) begin
   if (rst) begin
      current_osc_select <= `OSC_FRC;
   end else if (ce) begin
      if (any_src) begin
         if (two_speed_en && por_event) begin
            current_osc_select <= `OSC_FRC;
         end else if (!clk_switch_en || por_event || bor_event) begin
            current_osc_select <= initial_osc_select;
         end
      end
   end
end

// =====================================================
// Clock-fail monitor start
// Counting starts only once the system reset has been released
always @(posedge clk or posedge rst) begin
   if (rst) begin
      clock_fail_monitor_cnt <= 32'h00000000;
   end else if (ce) begin
      if (any_src) begin
         clock_fail_monitor_cnt <= 32'h00000000;
      end else if (clock_fail_monitor_run && clock_fail_monitor_cnt != `CLOCK_FAIL_MONITOR_CYCLES) begin
         clock_fail_monitor_cnt <= clock_fail_monitor_cnt + 32'h00000001;
      end
   end
end

always @(posedge clk or posedge rst) begin
   if (rst) begin
      clock_fail_monitor_on <= 1'b0;
   end else if (ce) begin
      if (any_src) begin
         clock_fail_monitor_on <= 1'b0;
      end else if (clock_fail_monitor_run && clock_fail_monitor_cnt == `CLOCK_FAIL_MONITOR_CYCLES) begin
         clock_fail_monitor_on <= 1'b1;
      end
   end
end
endmodule

// ---- verification/reset_flags_checker.sv ----
`timescale 1ns/100ps
// ==========
// Release and register checks
module reset_flags_checker (
   input wire clk,
   input wire rst,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   input wire [31:0] prdata,
   input wire por_event,
   input wire system_reset,
   input wire cpu_run,
   input wire clock_fail_monitor_on,
   input wire brownout_enable,
   input wire watchdog_enable,
   input wire watchdog_fuse_enable,
   input wire progmem_sleep_power
);
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   sequence s_wr; psel && penable && pwrite && paddr == 12'h000 && !por_event; endsequence
   sequence s_rel; $fell(system_reset); endsequence
   property p_por; por_event |=> system_reset; endproperty
   a_por: assert property (p_por) else $error("no reset");
   property p_clr; por_event |=> !brownout_enable; endproperty
   a_clr: assert property (p_clr) else $error("enable kept");
   property p_sb; s_wr |=> brownout_enable == $past(pwdata[13]); endproperty
   a_sb: assert property (p_sb) else $error("brownout enable");
   property p_pm; s_wr |=> progmem_sleep_power == $past(pwdata[8]); endproperty
   a_pm: assert property (p_pm) else $error("bias power");
   property p_wd; s_wr |=> watchdog_enable == ($past(pwdata[5]) | watchdog_fuse_enable); endproperty
   a_wd: assert property (p_wd) else $error("watchdog enable");
   property p_rsv; (prdata & 32'hffff1a00) == 32'h0; endproperty
   a_rsv: assert property (p_rsv) else $error("reserved bits");
   property p_run; $rose(cpu_run) |-> !system_reset; endproperty
   a_run: assert property (p_run) else $error("run in reset");
   property p_mon; s_rel |-> !clock_fail_monitor_on [*8]; endproperty
   a_mon: assert property (p_mon) else $error("monitor early");
endmodule

// ---- verification/reset_src_model.sv ----
`timescale 1ns/100ps
// ==========
// Reset sources and oscillator
module reset_src_model (
   input wire clk,
   output logic [7:0] ev = 8'h00,
   output logic pin_n = 1'b1,
   output logic osc = 1'b0
);
   // Crystal runs free and slower than clk, so the synchroniser sees every edge
   always #50 osc = ~osc;
   task pulse(input int k);
      @(posedge clk) {pin_n, ev} <= 9'h100 ^ (9'h001 << k);
      repeat ((k == 8) ? 4 : 1) @(posedge clk);
      {pin_n, ev} <= 9'h100;
   endtask
endmodule

// ---- verification/reset_flags_and_release_timing_test.sv ----
`timescale 1ns/100ps
// ==========
// Bench
module reset_flags_and_release_timing_test;
   logic clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, clk_switch_en = 1'b1;
   logic two_speed_en = 1'b0, needs_ost = 1'b0, needs_pll = 1'b0, pready, pslverr, system_reset, cpu_run;
   logic clock_fail_monitor_on, brownout_enable, watchdog_enable, progmem_sleep_power, pin_n, osc;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic [2:0] initial_osc_select = 3'h5, current_osc_select;
   logic [7:0] ev;
   logic deep_sleep_en = 1'b1, watchdog_fuse_enable = 1'b0, powerup_timer_en = 1'b1;
   int error_cnt = 0, n_checks = 0, n, f, r, k, lo;
   int ord [9] = '{0, 2, 3, 4, 5, 6, 7, 8, 1};
   localparam logic [8:0][15:0] ex = {16'h0080, 16'h0004, 16'h0408, 16'h4000, 16'h8000, 16'h0010, 16'h0040,
      16'h0002, 16'h0003};
   always #10 clk = ~clk;
   reset_src_model i_reset_src_model (.clk(clk), .ev(ev), .pin_n(pin_n), .osc(osc));
   reset_flags_and_release_timing #(.powerup_timer_cycles(32'h32), .por_cycles(32'ha), .lock_cycles(32'h14))
      i_reset_flags_and_release_timing (.*, .ce(1'b1), .clock_fail_monitor_en(1'b1),
      .por_event(ev[0]), .bor_event(ev[1]), .reset_instr(ev[2]),
      .wdt_timeout(ev[3]), .trap_conflict(ev[4]), .illegal_op(ev[5]), .sleep_instr(ev[6]),
      .idle_instr(ev[7]), .pin_reset_n(pin_n), .osc_tick(osc));
   task chk(input logic [31:0] g, e);
      n_checks++;
      if (g !== e) begin
         error_cnt++;
         $display("wrong value at %0t: got %h expected %h", $time, g, e);
      end
   endtask
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge clk) {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
      @(posedge clk) penable <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      rd = prdata;
      chk(pslverr, a != 12'h000);
      {psel, penable} <= 2'b00;
   endtask
   task fire(input int kind);
      i_reset_src_model.pulse(kind);
      @(posedge clk);
      for (n = 0; system_reset !== 1'b0; n++) @(posedge clk);
   endtask
   task t_regs;
      apb(1'b1, 12'h000, 32'hffffffff);
      apb(1'b0, 12'h008, 32'h0);
      apb(1'b0, 12'h000, 32'h0);
      chk(rd, 32'h0000e5ff);
      chk({brownout_enable, watchdog_enable, progmem_sleep_power, system_reset}, 32'he);
      $display("register test done");
   endtask
   task t_flags;
      foreach (ord[i]) begin
         k = ord[i];
         lo = (k == 0) ? 60 : (k == 1) ? 50 : 0;
         clk_switch_en <= (k != 8);
         apb(1'b1, 12'h000, (k == 0) ? 32'hffff : (k == 6) ? 32'h0010 : 32'h0);
         fire(k);
         chk(n >= lo && n <= lo + 6, 1'b1);
         apb(1'b0, 12'h000, 32'h0);
         chk(rd, {16'h0, ex[k]});
         chk(current_osc_select, (k == 1 || k == 8) ? 32'h2 : 32'h5);
         initial_osc_select <= 3'h2;
      end
      $display("flag test done");
   endtask
   task t_opts;
      watchdog_fuse_enable <= 1'b1;
      apb(1'b1, 12'h000, 32'h0);
      @(posedge clk);
      chk(watchdog_enable, 1'b1);
      watchdog_fuse_enable <= 1'b0;
      @(posedge clk);
      chk(watchdog_enable, 1'b0);
      deep_sleep_en <= 1'b0;
      fire(6);
      apb(1'b0, 12'h000, 32'h0);
      chk(rd, 32'h00000008);
      deep_sleep_en <= 1'b1;
      powerup_timer_en <= 1'b0;
      fire(1);
      chk(n <= 6, 1'b1);
      fire(0);
      chk(n >= 10 && n <= 16, 1'b1);
      powerup_timer_en <= 1'b1;
      $display("option test done");
   endtask
   task t_start;
      {two_speed_en, needs_ost, needs_pll} <= 3'b111;
      fire(0);
      chk(current_osc_select, 32'h0);
      f = 0;
      r = 0;
      while (cpu_run !== 1'b1 || clock_fail_monitor_on !== 1'b1) begin
         f += (clock_fail_monitor_on !== 1'b1);
         r += (cpu_run !== 1'b1);
         @(posedge clk);
      end
      chk(f >= 98 && f <= 104, 1'b1);
      // 1024 crystal periods of five clocks each, less the 60-cycle release already spent
      chk(r >= 5040 && r <= 5080, 1'b1);
      {two_speed_en, needs_ost, needs_pll} <= 3'b000;
      $display("start-up test done");
   endtask
   task end_sim;
      $display("checks %0d mismatches %0d", n_checks, error_cnt);
      if (error_cnt == 0 && n_checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   initial begin
      repeat (12) @(posedge clk);
      rst <= 1'b0;
      t_regs;
      t_flags;
      t_opts;
      t_start;
      end_sim;
   end
   initial begin
      #400000;
      error_cnt++;
      end_sim;
   end
endmodule
bind reset_flags_and_release_timing reset_flags_checker i_reset_flags_checker (.*);
